// ===== hw/gwm_monitor.sv
/*
  Gate waveform monitor: turn-on and turn-off timeout supervision and
  one-shot transition time capture, with an APB register slave.
  Assumes sequence events are one-cycle pulses from the driver core and
  the threshold comparators are already synchronous to clock.
*/
// The register addresses and the APB register port are this design's own decisions.
module gwm_monitor
  import gwm_pkg::*;
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Driver core sequence events
  input  wire logic        turnon_start,
  input  wire logic        turnoff_hard,
  input  wire logic        verification_mode,
  input  wire logic        weak_turn_on_mode,
  // Gate comparators
  input  wire logic        upper_gate_threshold,
  input  wire logic        lower_gate_threshold,
  // Error to the primary error register
  output logic             gate_timeout_error_flag
);

  // ==========================================================
  // Oscillator enables
  logic osc_tick;
  logic cap_tick;

  gwm_tick_div #(.LAST(GWM_OSC_DIV_LAST)) u_osc_div (
    .clock (clock),
    .rst   (rst),
    .tick  (osc_tick)
  );

  gwm_tick_div #(.LAST(GWM_CAP_DIV_LAST)) u_cap_div (
    .clock (clock),
    .rst   (rst),
    .tick  (cap_tick)
  );

  // ==========================================================
  // Sequence timers
  logic                on_armed_reg, on_armed_next;
  logic                off_armed_reg, off_armed_next;
  logic [7:0]          on_time_reg, on_time_next;
  logic [7:0]          off_time_reg, off_time_next;
  logic                err_reg, err_next;
  logic                on_supp;
  logic [GWM_NCH-1:0]  ch_start;
  logic [GWM_NCH-1:0]  ch_reached;
  logic [GWM_NCH-1:0]  ch_tick;

  gwm_tmr_if tif [GWM_NCH] ();

  assign on_supp = verification_mode | weak_turn_on_mode;

  assign ch_start[GWM_CH_ON_TO]   = turnon_start & ~on_supp; // [RULE5]
  assign ch_start[GWM_CH_OFF_TO]  = turnoff_hard; // [RULE4]
  assign ch_start[GWM_CH_ON_CAP]  = turnon_start & on_armed_reg; // [RULE7]
  assign ch_start[GWM_CH_OFF_CAP] = turnoff_hard & off_armed_reg; // [RULE7]

  assign ch_reached[GWM_CH_ON_TO]   = upper_gate_threshold; // [RULE2]
  assign ch_reached[GWM_CH_OFF_TO]  = lower_gate_threshold; // [RULE4]
  assign ch_reached[GWM_CH_ON_CAP]  = upper_gate_threshold;
  assign ch_reached[GWM_CH_OFF_CAP] = lower_gate_threshold;

  // Timeouts count on the main secondary oscillator, captures on the
  // faster capture oscillator for finer resolution.
  assign ch_tick[GWM_CH_ON_TO]   = osc_tick;
  assign ch_tick[GWM_CH_OFF_TO]  = osc_tick;
  assign ch_tick[GWM_CH_ON_CAP]  = cap_tick;
  assign ch_tick[GWM_CH_OFF_CAP] = cap_tick;

  for (genvar i = 0; i < GWM_NCH; i++) begin : g_ch
    assign tif[i].start   = ch_start[i];
    assign tif[i].reached = ch_reached[i];
    assign tif[i].tick    = ch_tick[i];
    gwm_seq_timer u_tmr (
      .clock (clock),
      .rst   (rst),
      .tif   (tif[i])
    );
  end

  // ==========================================================
  // APB access decode
  logic        setup_ph;
  logic        wr_acc;
  logic        arm_cmd;
  logic        err_clr;
  logic        rd_hit;
  logic [31:0] rd_data;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;

  assign setup_ph = psel & ~penable;
  assign wr_acc   = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign arm_cmd  = wr_acc & (paddr == GWM_CTRL_ADDR) &
                    pwdata[GWM_ARM_BIT];
  assign err_clr  = wr_acc & (paddr == GWM_STATUS_ADDR) &
                    pwdata[GWM_ERR_BIT];

  always_comb begin
    rd_data = GWM_RD_ZERO;
    rd_hit  = 1'b1;
    case (paddr)
      GWM_CTRL_ADDR: begin
        rd_data = GWM_RD_ZERO;
      end
      GWM_STATUS_ADDR: begin
        rd_data[GWM_ERR_BIT]     = err_reg;
        rd_data[GWM_OFF_ARM_BIT] = off_armed_reg;
        rd_data[GWM_ON_ARM_BIT]  = on_armed_reg;
        rd_data[GWM_ON_RUN_BIT]  = tif[GWM_CH_ON_TO].running;
        rd_data[GWM_OFF_RUN_BIT] = tif[GWM_CH_OFF_TO].running;
      end
      GWM_TIMES_ADDR: begin
        rd_data[GWM_ON_TIME_LSB +: 8]  = on_time_reg;
        rd_data[GWM_OFF_TIME_LSB +: 8] = off_time_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // Every access takes exactly one access cycle: the answer is prepared
  // in the setup cycle so that all bus outputs come from flip-flops.
  always_comb begin
    pready_next  = setup_ph;
    pslverr_next = setup_ph & ~rd_hit;
    prdata_next  = prdata_reg;
    if (setup_ph) begin
      prdata_next = pwrite ? GWM_RD_ZERO : rd_data;
    end
  end

  // ==========================================================
  // Error flag and capture state
  always_comb begin
    err_next       = err_reg;
    on_armed_next  = on_armed_reg;
    off_armed_next = off_armed_reg;
    on_time_next   = on_time_reg;
    off_time_next  = off_time_reg;
    if (err_clr) begin
      err_next = 1'b0;
    end
    // A timeout in the clearing cycle still lands in the flag.
    if (tif[GWM_CH_ON_TO].ovf | tif[GWM_CH_OFF_TO].ovf) begin
      err_next = 1'b1; // [RULE1] [RULE3]
    end
    if (tif[GWM_CH_ON_CAP].start) begin
      on_time_next = GWM_TIME_RST; // [RULE8]
    end else if (tif[GWM_CH_ON_CAP].done) begin
      on_time_next  = tif[GWM_CH_ON_CAP].count; // [RULE8]
      on_armed_next = 1'b0;
    end else if (tif[GWM_CH_ON_CAP].ovf) begin
      on_time_next  = GWM_CNT_MAX; // [RULE9]
      on_armed_next = 1'b0;
    end
    if (tif[GWM_CH_OFF_CAP].start) begin
      off_time_next = GWM_TIME_RST; // [RULE10]
    end else if (tif[GWM_CH_OFF_CAP].done) begin
      off_time_next  = tif[GWM_CH_OFF_CAP].count; // [RULE10]
      off_armed_next = 1'b0;
    end else if (tif[GWM_CH_OFF_CAP].ovf) begin
      off_time_next  = GWM_CNT_MAX; // [RULE9]
      off_armed_next = 1'b0;
    end
    // Re-arming wins over a completion landing in the same cycle.
    if (arm_cmd) begin
      on_armed_next  = 1'b1; // [RULE6]
      off_armed_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      err_reg       <= 1'b0;
      on_armed_reg  <= 1'b0;
      off_armed_reg <= 1'b0;
      on_time_reg   <= GWM_TIME_RST;
      off_time_reg  <= GWM_TIME_RST;
      prdata_reg    <= GWM_RD_ZERO;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
    end else begin
      err_reg       <= err_next;
      on_armed_reg  <= on_armed_next;
      off_armed_reg <= off_armed_next;
      on_time_reg   <= on_time_next; // [RULE11]
      off_time_reg  <= off_time_next; // [RULE11]
      prdata_reg    <= prdata_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  assign prdata                  = prdata_reg;
  assign pready                  = pready_reg;
  assign pslverr                 = pslverr_reg;
  assign gate_timeout_error_flag = err_reg;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_on_measure;
    turnon_start && on_armed_reg ##1 tif[GWM_CH_ON_CAP].running;
  endsequence

  sequence s_off_measure;
    turnoff_hard && off_armed_reg ##1 tif[GWM_CH_OFF_CAP].running;
  endsequence

  a_apb_one_wait: assert property (
    setup_ph |=> pready && !$past(pready)
  ) else $error("access cycle did not answer at once");

  a_timeout_err_set: assert property ( // [RULE3]
    (tif[GWM_CH_ON_TO].ovf || tif[GWM_CH_OFF_TO].ovf) |=> err_reg
  ) else $error("timeout overflow did not set the error flag");

  // The flag is sticky, so only a software clear may drop it.
  a_err_sticky: assert property ( // [RULE3]
    err_reg && !err_clr |=> err_reg
  ) else $error("error flag fell without a clear");

  a_err_clear: assert property ( // [RULE3]
    err_clr && !tif[GWM_CH_ON_TO].ovf &&
      !tif[GWM_CH_OFF_TO].ovf |=> !err_reg
  ) else $error("error flag not cleared by software");

  a_on_timeout_start: assert property ( // [RULE2]
    turnon_start && !on_supp |=>
      tif[GWM_CH_ON_TO].running && tif[GWM_CH_ON_TO].count == 8'h00
  ) else $error("turn-on timeout did not restart from zero");

  a_on_timeout_mode: assert property ( // [RULE5]
    turnon_start && on_supp && !tif[GWM_CH_ON_TO].running |=>
      !tif[GWM_CH_ON_TO].running
  ) else $error("turn-on timeout ran in a test mode");

  a_off_timeout_start: assert property ( // [RULE4]
    turnoff_hard |=> tif[GWM_CH_OFF_TO].running &&
      tif[GWM_CH_OFF_TO].count == 8'h00
  ) else $error("turn-off timeout did not restart from zero");

  a_on_timeout_stop: assert property ( // [RULE2]
    tif[GWM_CH_ON_TO].running && upper_gate_threshold &&
      !tif[GWM_CH_ON_TO].start |=> !tif[GWM_CH_ON_TO].running
  ) else $error("turn-on timeout ran past the upper threshold");

  a_off_timeout_stop: assert property ( // [RULE4]
    tif[GWM_CH_OFF_TO].running && lower_gate_threshold &&
      !tif[GWM_CH_OFF_TO].start |=> !tif[GWM_CH_OFF_TO].running
  ) else $error("turn-off timeout ran past the lower threshold");

  a_arm_sets_both: assert property ( // [RULE6]
    arm_cmd |=> on_armed_reg && off_armed_reg
  ) else $error("arm command did not set both armed bits");

  a_on_cap_clear: assert property ( // [RULE8]
    s_on_measure |-> on_time_reg == 8'h00
  ) else $error("turn-on time not cleared at sequence start");

  a_on_cap_store: assert property ( // [RULE8]
    tif[GWM_CH_ON_CAP].done && !arm_cmd |=>
      on_time_reg == $past(tif[GWM_CH_ON_CAP].count) && !on_armed_reg
  ) else $error("turn-on time not stored or still armed");

  a_off_cap_store: assert property ( // [RULE10]
    tif[GWM_CH_OFF_CAP].done |=>
      off_time_reg == $past(tif[GWM_CH_OFF_CAP].count)
  ) else $error("turn-off time not stored");

  a_off_cap_clear: assert property ( // [RULE10]
    s_off_measure |-> off_time_reg == 8'h00
  ) else $error("turn-off time not cleared at hard transition");

  a_cap_ovf_ones: assert property ( // [RULE9]
    tif[GWM_CH_ON_CAP].ovf |=> on_time_reg == GWM_CNT_MAX
  ) else $error("turn-on capture overflow did not store all ones");

  a_off_cap_ovf: assert property ( // [RULE9]
    tif[GWM_CH_OFF_CAP].ovf |=> off_time_reg == GWM_CNT_MAX
  ) else $error("turn-off capture overflow did not store all ones");

  a_unarmed_hold: assert property ( // [RULE11]
    !on_armed_reg && !tif[GWM_CH_ON_CAP].running |=> $stable(on_time_reg)
  ) else $error("turn-on time changed while not armed");

  a_off_unarmed_hold: assert property ( // [RULE11]
    !off_armed_reg && !tif[GWM_CH_OFF_CAP].running |=>
      $stable(off_time_reg)
  ) else $error("turn-off time changed while not armed");

  a_off_cap_disarm: assert property ( // [RULE10]
    tif[GWM_CH_OFF_CAP].done && !arm_cmd |=> !off_armed_reg
  ) else $error("turn-off capture still armed after storing");

endmodule : gwm_monitor

// ===== hw/gwm_pkg.sv
/*
  Constants shared by the gate waveform monitor: register map, field
  positions, reset values and oscillator divider counts.
  Assumes a single 20 MHz system clock and an APB master on the bus.
*/
// Operation
// [RULE1] Time both turn-on and turn-off sequences.
// [RULE2] Turn-on start clears counter; upper threshold stops.
// [RULE3] Timeout overflow sets the gate timeout error.
// [RULE4] Turn-off hard transition restarts; lower threshold stops.
// [RULE5] Verification or weak modes skip turn-on timeout.
// [RULE6] Arm write sets both capture armed bits.
// [RULE7] Armed capture measures next on and off.
// [RULE8] Turn-on capture clears, counts, stores, disarms.
// [RULE9] Capture counter overflow stores all ones.
// [RULE10] Turn-off capture clears, counts, stores, disarms.
// [RULE11] Unarmed capture fields keep their stored value.
package gwm_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0] GWM_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] GWM_STATUS_ADDR = 8'h04;
  localparam logic [7:0] GWM_TIMES_ADDR  = 8'h08;

  // ==========================================================
  // Field positions
  localparam int GWM_ARM_BIT     = 0;
  localparam int GWM_ERR_BIT     = 0;
  localparam int GWM_OFF_ARM_BIT = 1;
  localparam int GWM_ON_ARM_BIT  = 2;
  localparam int GWM_ON_RUN_BIT  = 3;
  localparam int GWM_OFF_RUN_BIT = 4;
  localparam int GWM_ON_TIME_LSB  = 0;
  localparam int GWM_OFF_TIME_LSB = 8;

  // ==========================================================
  // Reset values and counter limits
  localparam logic [7:0]  GWM_TIME_RST = 8'h00;
  localparam logic [7:0]  GWM_CNT_MAX  = 8'hFF;
  localparam logic [31:0] GWM_RD_ZERO  = 32'h00000000;

  // ==========================================================
  // Oscillator rates as terminal counts of the 20 MHz clock dividers
  localparam logic [7:0] GWM_OSC_DIV_LAST = 8'h03;
  localparam logic [7:0] GWM_CAP_DIV_LAST = 8'h01;

  // Channel indices of the four sequence timers.
  localparam int GWM_CH_ON_TO   = 0;
  localparam int GWM_CH_OFF_TO  = 1;
  localparam int GWM_CH_ON_CAP  = 2;
  localparam int GWM_CH_OFF_CAP = 3;
  localparam int GWM_NCH        = 4;

endpackage : gwm_pkg

// ===== hw/gwm_seq_timer.sv
/*
  One 8-bit sequence timer: start clears and runs it, the threshold
  flag stops it, counting past the top ends it with an overflow.
  Assumes start is a one-cycle pulse and tick a one-cycle enable.
*/
module gwm_seq_timer
  import gwm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control side
  gwm_tmr_if.timer tif
);

  logic       run_reg, run_next;
  logic [7:0] cnt_reg, cnt_next;

  // ==========================================================
  // Counter
  // A start that meets a running count restarts it, so a new sequence
  // is never measured against the tail of the previous one.
  always_comb begin
    run_next = run_reg;
    cnt_next = cnt_reg;
    if (tif.start) begin
      run_next = 1'b1;
      cnt_next = GWM_TIME_RST;
    end else if (run_reg) begin
      if (tif.reached) begin
        run_next = 1'b0;
      end else if (tif.tick) begin
        if (cnt_reg == GWM_CNT_MAX) begin
          run_next = 1'b0;
        end else begin
          cnt_next = cnt_reg + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_reg <= 1'b0;
      cnt_reg <= GWM_TIME_RST;
    end else begin
      run_reg <= run_next;
      cnt_reg <= cnt_next;
    end
  end

  assign tif.running = run_reg;
  assign tif.count   = cnt_reg;
  assign tif.done    = run_reg & tif.reached & ~tif.start;
  assign tif.ovf     = run_reg & ~tif.reached & ~tif.start & tif.tick &
                       (cnt_reg == GWM_CNT_MAX);

endmodule : gwm_seq_timer

// ===== hw/gwm_tick_div.sv
/*
  Divider that turns the system clock into a one-cycle enable pulse
  standing in for a slower oscillator domain.
  Assumes LAST is the terminal count, one less than the division.
*/
module gwm_tick_div
  import gwm_pkg::*;
#(
  parameter logic [7:0] LAST = 8'h01
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Enable pulse
  output logic      tick
);

  logic [7:0] cnt_reg,  cnt_next;
  logic       tick_reg, tick_next;

  // ==========================================================
  // Divider
  always_comb begin
    cnt_next  = cnt_reg + 8'h01;
    tick_next = 1'b0;
    if (cnt_reg == LAST) begin
      cnt_next  = 8'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule : gwm_tick_div

// ===== hw/gwm_tmr_if.sv
/*
  Carrier between the monitor top and one sequence timer.
  Assumes the top drives start, reached and tick each cycle.
*/
interface gwm_tmr_if;
  logic       start;
  logic       reached;
  logic       tick;
  logic       running;
  logic       done;
  logic       ovf;
  logic [7:0] count;

  modport timer (input start, input reached, input tick,
                 output running, output done, output ovf, output count);
  modport ctrl  (output start, output reached, output tick,
                 input running, input done, input ovf, input count);
endinterface : gwm_tmr_if

// ===== testbench/gate_waveform_monitor_bench.sv
/*
  Self-checking bench for the gate waveform monitor with a gate model.
  Assumes the APB slave answers in the cycle after setup and the
  capture clock ticks every 2 cycles, so times are checked within 1.
*/
module gate_waveform_monitor_bench
  import gwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [31:0] exp;
    logic [31:0] msk;
    int          sh;
    int          tol;
    logic        slv;
  } gwm_note_t;

  logic        clock, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        turnon_start, turnoff_hard;
  logic        verification_mode, weak_turn_on_mode;
  logic        upper_gate_threshold, lower_gate_threshold;
  logic        gate_timeout_error_flag;
  logic [15:0] delay_on, delay_off;
  int          fail_count, n_compared;
  gwm_note_t   notes[$];

  gwm_monitor dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .turnon_start(turnon_start), .turnoff_hard(turnoff_hard),
    .verification_mode(verification_mode),
    .weak_turn_on_mode(weak_turn_on_mode),
    .upper_gate_threshold(upper_gate_threshold),
    .lower_gate_threshold(lower_gate_threshold),
    .gate_timeout_error_flag(gate_timeout_error_flag));

  gwm_gate_model gate (.clock(clock), .rst(rst),
    .turnon_start(turnon_start), .turnoff_hard(turnoff_hard),
    .delay_on(delay_on), .delay_off(delay_off),
    .upper_gate_threshold(upper_gate_threshold),
    .lower_gate_threshold(lower_gate_threshold));

  always #25 clock = ~clock;

  // ==========================================================
  // Checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // The tick phase is unknown to the bench, so a field within the
  // tolerance of its note is taken as a match.
  always @(posedge clock) begin : watch
    gwm_note_t   n;
    logic [31:0] f;
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      n = notes.pop_front();
      f = (prdata >> n.sh) & n.msk;
      if (f + n.tol >= n.exp && f <= n.exp + n.tol) begin
        f = n.exp;
      end
      check(f, n.exp);
      check({31'h00000000, pslverr}, {31'h00000000, n.slv});
      if (paddr === GWM_STATUS_ADDR && n.msk[0]) begin
        check({31'h00000000, gate_timeout_error_flag},
              {31'h00000000, n.exp[0]});
      end
    end
  end

  initial begin : watchdog
    repeat (20000) @(posedge clock);
    fail_count++;
    complete_run();
  end

  // ==========================================================
  // Drivers
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input gwm_note_t n);
    int k;
    notes.push_back(n);
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) fail_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input int sh, input int tol);
    apb(1'b0, a, 32'h00000000, '{e, m, sh, tol, 1'b0});
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic slv);
    apb(1'b1, a, d, '{32'h00000000, 32'h00000000, 0, 0, slv});
  endtask : wr

  task automatic pulse(input logic off, input logic [15:0] d);
    @(posedge clock);
    if (off) begin
      delay_off    <= d;
      turnoff_hard <= 1'b1;
    end else begin
      delay_on     <= d;
      turnon_start <= 1'b1;
    end
    @(posedge clock);
    turnon_start <= 1'b0;
    turnoff_hard <= 1'b0;
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask : idle

  // ==========================================================
  // Test sequence
  initial begin : main
    logic [15:0] d1, d2;
    logic [31:0] e1;
    clock = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, turnon_start, turnoff_hard} = 5'h00;
    {verification_mode, weak_turn_on_mode} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {delay_on, delay_off} = 32'h00000000;
    fail_count = 0;
    n_compared = 0;
    void'($urandom(82784));
    idle(20);
    rst <= 1'b0;
    rd(GWM_CTRL_ADDR, 32'h00000000, 32'hFFFFFFFF, 0, 0);
    rd(GWM_STATUS_ADDR, 32'h00000000, 32'hFFFFFFFF, 0, 0);
    rd(GWM_TIMES_ADDR, 32'h00000000, 32'hFFFFFFFF, 0, 0);
    wr(8'h0C, 32'hFFFFFFFF, 1'b1);
    apb(1'b0, 8'h0C, 32'h00000000, '{32'h0, 32'hFFFFFFFF, 0, 0, 1'b1});
    $display("test reset done");
    wr(GWM_CTRL_ADDR, 32'h00000001, 1'b0);
    rd(GWM_STATUS_ADDR, 32'h00000006, 32'h0000001F, 0, 0);
    d1 = 16'h0014 + 16'($urandom % 60);
    e1 = 32'((d1 + 1) / 2);
    pulse(1'b0, d1);
    rd(GWM_STATUS_ADDR, 32'h0000000E, 32'h0000001F, 0, 0);
    idle(int'(d1) + 10);
    rd(GWM_TIMES_ADDR, e1, 32'h000000FF, 0, 1);
    rd(GWM_STATUS_ADDR, 32'h00000002, 32'h0000001F, 0, 0);
    d2 = 16'h0014 + 16'($urandom % 60);
    pulse(1'b1, d2);
    rd(GWM_STATUS_ADDR, 32'h00000012, 32'h0000001F, 0, 0);
    idle(int'(d2) + 10);
    rd(GWM_TIMES_ADDR, 32'((d2 + 1) / 2), 32'h000000FF, 8, 1);
    rd(GWM_STATUS_ADDR, 32'h00000000, 32'h0000001F, 0, 0);
    pulse(1'b0, d1 + 16'h0096);
    idle(int'(d1) + 160);
    rd(GWM_TIMES_ADDR, e1, 32'h000000FF, 0, 1);
    $display("test capture done");
    wr(GWM_CTRL_ADDR, 32'h00000001, 1'b0);
    pulse(1'b0, 16'h0000);
    idle(600);
    rd(GWM_TIMES_ADDR, 32'h000000FF, 32'h000000FF, 0, 0);
    rd(GWM_STATUS_ADDR, 32'h0000000A, 32'h0000001F, 0, 0);
    idle(600);
    rd(GWM_STATUS_ADDR, 32'h00000003, 32'h00000007, 0, 0);
    wr(GWM_STATUS_ADDR, 32'h00000001, 1'b0);
    rd(GWM_STATUS_ADDR, 32'h00000000, 32'h00000001, 0, 0);
    pulse(1'b1, 16'h000A);
    idle(20);
    rd(GWM_TIMES_ADDR, 32'h00000005, 32'h000000FF, 8, 1);
    $display("test overflow done");
    for (int m = 0; m < 2; m++) begin
      verification_mode <= (m == 0);
      weak_turn_on_mode <= (m == 1);
      pulse(1'b0, 16'h0000);
      idle(1200);
      rd(GWM_STATUS_ADDR, 32'h00000000, 32'h00000001, 0, 0);
      wr(GWM_CTRL_ADDR, 32'h00000001, 1'b0);
      pulse(1'b1, 16'h0000);
      idle(1200);
      rd(GWM_STATUS_ADDR, 32'h00000001, 32'h00000001, 0, 0);
      rd(GWM_TIMES_ADDR, 32'h000000FF, 32'h000000FF, 8, 0);
      wr(GWM_STATUS_ADDR, 32'h00000001, 1'b0);
      rd(GWM_STATUS_ADDR, 32'h00000000, 32'h00000001, 0, 0);
    end
    verification_mode <= 1'b0;
    weak_turn_on_mode <= 1'b0;
    $display("test modes done");
    complete_run();
  end
endmodule : gate_waveform_monitor_bench

// ===== testbench/gwm_gate_model.sv
/*
  Behavioural model of the switch gate seen through the two threshold
  comparators of the gate waveform monitor.
  Assumes one-cycle sequence pulses and delays set before each pulse;
  a delay of zero leaves the gate stuck so that a timeout can occur.
*/
module gwm_gate_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Sequence events and gate delays in clock cycles
  input  wire logic        turnon_start,
  input  wire logic        turnoff_hard,
  input  wire logic [15:0] delay_on,
  input  wire logic [15:0] delay_off,
  // Comparator levels
  output logic             upper_gate_threshold,
  output logic             lower_gate_threshold
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================
  // Gate charge and discharge
  int   cnt;
  logic rising;

  // The gate leaves its old threshold at once but takes the chosen
  // delay to reach the other one, so slow and prompt gates both occur.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt                  <= 0;
      rising               <= 1'b0;
      upper_gate_threshold <= 1'b0;
      lower_gate_threshold <= 1'b1;
    end else if (turnon_start) begin
      cnt                  <= 0;
      rising               <= 1'b1;
      upper_gate_threshold <= 1'b0;
      lower_gate_threshold <= 1'b0;
    end else if (turnoff_hard) begin
      cnt                  <= 0;
      rising               <= 1'b0;
      upper_gate_threshold <= 1'b0;
    end else begin
      cnt <= cnt + 1;
      if (rising && delay_on != 16'h0000 && cnt + 1 == int'(delay_on)) begin
        upper_gate_threshold <= 1'b1;
      end
      if (!rising && delay_off != 16'h0000 &&
          cnt + 1 == int'(delay_off)) begin
        lower_gate_threshold <= 1'b1;
      end
    end
  end
endmodule : gwm_gate_model
